//--- i2c_slave_serial_port.sv
// Operation
// R1: Port is inert until the port enable control bit 5 is set.
// R2: Control bits 3..0 pick one of five bus modes.
// R3: Pins are open-drain only when enabled, bus mode, both direction bits input.
// R4: Slave serves 7-bit and 10-bit own addresses, ignores general call.
// R5: As slave-transmitter the port drives outgoing data onto the data line.
// R6: After enable, wait for START, then shift 8 bits on rising clock edges.
// R7: On falling edge of eighth clock compare shift bits 7..1 with own address.
// R8: Match with buffer empty and no overflow: load buffer, set full, ACK, flag.
// R9: Buffer full or overflow: no load, no ACK, interrupt flag still set.
// R10: Byte arriving while buffer full sets the overflow flag.
// R11: Buffer read clears full; overflow cleared only by control write.
// R12: Software clears the interrupt flag each byte and reads status.
// R13: 10-bit header 11110 A9 A8 write must come first from master.
// R14: Each 10-bit address byte sets flag, full, update; address write releases clock.
// R15: 10-bit read after repeated START: flag and full set, update not set.
// R16: Matched write address clears read/write status and loads buffer.
// R17: One interrupt per data byte, received or transmitted.
// R18: Matched read address sets read/write, loads buffer, ACKs, holds clock low.
// R19: Software writes buffer, loading shift register, then sets clock release.
// R20: Transmit eight bits, changing data on falling clock edges.
// R21: Master acknowledge latched on ninth rising edge; NACK ends transfer, resets status.
// R22: On master ACK software loads next byte and sets clock release.
// R23: Master checks clock line before each pulse because slave may stretch.
// R24: Clock release bit 0 holds clock low, 1 releases it.
// R25: Mode codes 0110, 0111, 1011, 1110, 1111 as defined.
// R26: Start and stop flags show last condition; cleared at reset and disabled.
// R27: Bytes shift most significant bit first both directions.
`timescale 1ns/1ps
module i2c_slave_serial_port (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Software access to control register
  input  wire logic                i_ctl_wr,
  input  wire logic [7:0]          i_ctl_wdata,
  output logic      [7:0]          o_control,
  // Software access to buffer register
  input  wire logic                i_buf_wr,
  input  wire logic [7:0]          i_buf_wdata,
  input  wire logic                i_buf_rd,
  output logic      [7:0]          o_buffer,
  // Software access to own-address register
  input  wire logic                i_addr_wr,
  input  wire logic [7:0]          i_addr_wdata,
  output logic      [7:0]          o_own_addr,
  // Status and interrupt flag
  output logic      [7:0]          o_status,
  input  wire logic                i_irq_clr,
  output logic                     o_port_irq,
  // Pin direction bits, 1 = input
  input  wire logic [1:0]          i_pin_dir,
  // Clock pin
  input  wire logic                i_scl,
  output logic                     o_scl,
  output logic                     o_scl_oe_n,
  // Data pin
  input  wire logic                i_sda,
  output logic                     o_sda,
  output logic                     o_sda_oe_n
);
  import i2c_slave_pkg::*;

  bus_t       bus;
  state_t     state_q,  state_d;
  phase_t     phase_q,  phase_d;
  logic [7:0] ctl_q,    ctl_d;
  logic [7:0] stat_q,   stat_d;
  logic [7:0] addr_q,   addr_d;
  logic [7:0] buf_q,    buf_d;
  logic [7:0] sr_q,     sr_d;
  logic [3:0] cnt_q,    cnt_d;
  logic       ack_q,    ack_d;
  logic       irq_q,    irq_d;
  logic       hi_q,     hi_d;
  logic       scl_lo_q, scl_lo_d;
  logic       sda_lo_q, sda_lo_d;

  logic [3:0] mode;
  logic       bus_mode;
  logic       slave_on;
  logic       ten_bit;
  logic       sp_irq;
  logic       active;
  logic       match;
  logic       go_tx;
  logic       is_addr;

  bus_line_sync u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_scl (i_scl),
    .i_sda (i_sda),
    .o_bus (bus)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    mode     = ctl_q[CTL_MODE +: 4];
    bus_mode = (mode == MODE_SLV7) || (mode == MODE_SLV10) || (mode == MODE_FWM) ||
               (mode == MODE_SLV7_SP) || (mode == MODE_SLV10_SP);        // R2 R25
    slave_on = bus_mode && (mode != MODE_FWM);
    ten_bit  = (mode == MODE_SLV10) || (mode == MODE_SLV10_SP);
    sp_irq   = (mode == MODE_FWM) || (mode == MODE_SLV7_SP) || (mode == MODE_SLV10_SP);
    active   = ctl_q[CTL_EN] && bus_mode;                                  // R1
  end

  // ----------------------------------------------------------------
  // Address match on the received byte
  // ----------------------------------------------------------------
  always_comb begin
    match   = 1'b0;
    go_tx   = 1'b0;
    is_addr = (phase_q != PH_DATA);
    case (phase_q)
      PH_ADDR: begin
        if (!ten_bit) begin
          match = (sr_q[7:1] == addr_q[7:1]) && (sr_q[7:1] != 7'h00);      // R7 R4
          go_tx = sr_q[0];
        end else if ((sr_q[7:3] == HDR10) && (sr_q[2:1] == addr_q[2:1])) begin
          match = !sr_q[0] || hi_q;                                        // R13 R15
          go_tx = sr_q[0];
        end
      end
      PH_LOW: begin
        match = (sr_q == addr_q);
      end
      PH_DATA: begin
        match = 1'b1;
      end
      default: begin
        match = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    phase_d  = phase_q;
    ctl_d    = ctl_q;
    stat_d   = stat_q;
    addr_d   = addr_q;
    buf_d    = buf_q;
    sr_d     = sr_q;
    cnt_d    = cnt_q;
    ack_d    = ack_q;
    irq_d    = irq_q;
    hi_d     = hi_q;
    scl_lo_d = 1'b0;
    sda_lo_d = 1'b0;

    // Software side effects first, so hardware sets win over clears
    if (i_irq_clr) begin
      irq_d = 1'b0;
    end
    if (i_buf_rd) begin
      stat_d[ST_BF] = 1'b0;                                                // R11
    end
    if (i_ctl_wr) begin
      ctl_d = i_ctl_wdata;                                                 // R11
    end
    if (i_addr_wr) begin
      addr_d       = i_addr_wdata;
      stat_d[ST_UA] = 1'b0;                                                // R14
    end
    if (i_buf_wr) begin
      buf_d          = i_buf_wdata;
      sr_d           = i_buf_wdata;                                        // R19
      stat_d[ST_BF]  = 1'b1;
      if (state_q == S_TX && cnt_q != 4'h0) begin
        ctl_d[CTL_WCOL] = 1'b1;
      end
    end

    if (!active) begin
      state_d          = S_IDLE;                                           // R1
      phase_d          = PH_ADDR;
      cnt_d            = 4'h0;
      hi_d             = 1'b0;
      stat_d[ST_START] = 1'b0;                                             // R26
      stat_d[ST_STOP]  = 1'b0;
    end else if (bus.start) begin
      stat_d[ST_START] = 1'b1;                                             // R26
      stat_d[ST_STOP]  = 1'b0;
      if (sp_irq) begin
        irq_d = 1'b1;
      end
      if (slave_on) begin
        state_d = S_RX;                                                    // R6
        phase_d = PH_ADDR;
        cnt_d   = 4'h0;
      end
    end else if (bus.stop) begin
      stat_d[ST_STOP]  = 1'b1;                                             // R26
      stat_d[ST_START] = 1'b0;
      if (sp_irq) begin
        irq_d = 1'b1;
      end
      state_d = S_IDLE;
      phase_d = PH_ADDR;
      hi_d    = 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_d = 4'h0;
        end
        S_RX: begin
          if (bus.scl_rise && cnt_q != BITS_PER_BYTE) begin
            sr_d  = {sr_q[6:0], bus.sda};                                  // R6 R27
            cnt_d = cnt_q + 4'h1;
          end else if (bus.scl_fall && cnt_q == BITS_PER_BYTE) begin
            if (!match) begin
              state_d = S_IDLE;                                            // R4
            end else begin
              state_d = S_ACK;
              ack_d   = !stat_q[ST_BF] && !ctl_q[CTL_OV];
              if (!stat_q[ST_BF] && !ctl_q[CTL_OV]) begin
                buf_d         = sr_q;                                      // R8
                stat_d[ST_BF] = 1'b1;
              end
              if (stat_q[ST_BF]) begin
                ctl_d[CTL_OV] = 1'b1;                                      // R10 R9
              end
              stat_d[ST_DA] = !is_addr;
              if (is_addr) begin
                stat_d[ST_RW] = go_tx;                                     // R16 R18
              end
              if (ten_bit && is_addr && !go_tx) begin
                stat_d[ST_UA] = 1'b1;                                      // R14
              end
              if (phase_q == PH_ADDR && !(ten_bit && !go_tx)) begin
                phase_d = PH_DATA;
              end else if (phase_q == PH_ADDR) begin
                phase_d = PH_LOW;                                          // R13
              end else if (phase_q == PH_LOW) begin
                phase_d = PH_DATA;
                hi_d    = 1'b1;
              end
            end
          end
        end
        S_ACK: begin
          sda_lo_d = ack_q;                                                // R8
          if (bus.scl_fall) begin
            irq_d    = 1'b1;                                               // R8 R9 R17
            sda_lo_d = 1'b0;
            cnt_d    = 4'h0;
            if (stat_q[ST_RW] && ack_q) begin
              state_d         = S_TX;
              ctl_d[CTL_CKP]  = i_ctl_wr && i_ctl_wdata[CTL_CKP];          // R18
            end else begin
              state_d = S_RX;
            end
          end
        end
        S_TX: begin
          sda_lo_d = !sr_q[7];                                             // R5 R27
          if (bus.scl_fall) begin
            sr_d  = {sr_q[6:0], 1'b1};                                     // R20
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BITS_PER_BYTE - 4'h1) begin
              state_d       = S_TXACK;
              sda_lo_d      = 1'b0;
              stat_d[ST_BF] = 1'b0;
            end else begin
              sda_lo_d = !sr_q[6];
            end
          end
        end
        S_TXACK: begin
          if (bus.scl_rise) begin
            ack_d = !bus.sda;                                              // R21
            if (bus.sda) begin
              phase_d         = PH_ADDR;
              stat_d[ST_DA]   = 1'b0;
              stat_d[ST_RW]   = 1'b0;
              stat_d[ST_UA]   = 1'b0;
              stat_d[ST_BF]   = 1'b0;
            end
          end else if (bus.scl_fall) begin
            irq_d          = 1'b1;                                         // R17
            state_d        = ack_q ? S_TX : S_IDLE;                        // R21
            cnt_d          = 4'h0;
            stat_d[ST_DA]  = ack_q;
            ctl_d[CTL_CKP] = i_ctl_wr && i_ctl_wdata[CTL_CKP];             // R22
          end
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end

    // Clock stretch while release bit is low or an address update is pending
    if (active && slave_on && (!ctl_d[CTL_CKP] || stat_d[ST_UA]) &&
        (state_d == S_TX || state_d == S_RX || state_d == S_ACK)) begin
      scl_lo_d = !(state_d == S_ACK) && (state_q != S_RX || cnt_q == 4'h0); // R24 R14
    end
    if (!active || !slave_on) begin
      sda_lo_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q  <= S_IDLE;
      phase_q  <= PH_ADDR;
      ctl_q    <= CTL_RESET;
      stat_q   <= STAT_RESET;
      addr_q   <= ADDR_RESET;
      buf_q    <= BUF_RESET;
      sr_q     <= BUF_RESET;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      irq_q    <= 1'b0;
      hi_q     <= 1'b0;
      scl_lo_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      phase_q  <= phase_d;
      ctl_q    <= ctl_d;
      stat_q   <= stat_d;
      addr_q   <= addr_d;
      buf_q    <= buf_d;
      sr_q     <= sr_d;
      cnt_q    <= cnt_d;
      ack_q    <= ack_d;
      irq_q    <= irq_d;
      hi_q     <= hi_d;
      scl_lo_q <= scl_lo_d;
      sda_lo_q <= sda_lo_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, open drain only with both pins as inputs
  // ----------------------------------------------------------------
  always_comb begin
    o_control  = ctl_q;
    o_status   = stat_q;
    o_buffer   = buf_q;
    o_own_addr = addr_q;
    o_port_irq = irq_q;
    o_scl      = 1'b0;
    o_sda      = 1'b0;
    o_scl_oe_n = !(scl_lo_q && active && i_pin_dir[DIR_SCL] && i_pin_dir[DIR_SDA]); // R3
    o_sda_oe_n = !(sda_lo_q && active && i_pin_dir[DIR_SCL] && i_pin_dir[DIR_SDA]); // R3
  end

endmodule

//--- i2c_slave_pkg.sv
package i2c_slave_pkg;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_WCOL = 7;
  localparam int CTL_OV   = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  localparam int CTL_MODE = 0;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_DA    = 5;
  localparam int ST_STOP  = 4;
  localparam int ST_START = 3;
  localparam int ST_RW    = 2;
  localparam int ST_UA    = 1;
  localparam int ST_BF    = 0;

  // ----------------------------------------------------------------
  // Reset values, mode codes, address pattern
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET  = 8'h00;

  localparam logic [3:0] MODE_SLV7     = 4'h6;
  localparam logic [3:0] MODE_SLV10    = 4'h7;
  localparam logic [3:0] MODE_FWM      = 4'hB;
  localparam logic [3:0] MODE_SLV7_SP  = 4'hE;
  localparam logic [3:0] MODE_SLV10_SP = 4'hF;

  localparam logic [4:0] HDR10         = 5'h1E;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam int DIR_SCL = 0;
  localparam int DIR_SDA = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RX    = 3'b001,
    S_ACK   = 3'b011,
    S_TX    = 3'b010,
    S_TXACK = 3'b110
  } state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_LOW  = 2'b01,
    PH_DATA = 2'b11
  } phase_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_t;

endpackage

//--- bus_line_sync.sv
`timescale 1ns/1ps
module bus_line_sync (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  // Bus lines
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  // Sampled lines and events
  output i2c_slave_pkg::bus_t      o_bus
);
  import i2c_slave_pkg::*;

  logic [1:0] line_in;
  logic [1:0] meta_q;
  logic [1:0] meta_d;
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic [1:0] prev_q;
  logic [1:0] prev_d;

  assign line_in = {i_sda, i_scl};

  // ----------------------------------------------------------------
  // Two-stage synchroniser per line, idle high
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      always_comb begin
        meta_d[g] = line_in[g];
        sync_d[g] = meta_q[g];
        prev_d[g] = sync_q[g];
      end
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
          prev_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= meta_d[g];
          sync_q[g] <= sync_d[g];
          prev_q[g] <= prev_d[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edges and bus conditions
  // ----------------------------------------------------------------
  always_comb begin
    o_bus.scl      = sync_q[0];
    o_bus.sda      = sync_q[1];
    o_bus.scl_rise = sync_q[0] & ~prev_q[0];
    o_bus.scl_fall = ~sync_q[0] & prev_q[0];
    o_bus.start    = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
    o_bus.stop     = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];
  end

endmodule

//--- i2c_slave_serial_port_monitor.sv
`timescale 1ns/1ps
module i2c_slave_serial_port_monitor (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Software strobes and pin direction bits
  input  wire logic       i_ctl_wr,
  input  wire logic       i_buf_wr,
  input  wire logic       i_irq_clr,
  input  wire logic [1:0] i_pin_dir,
  // Design outputs
  input  wire logic [7:0] o_control,
  input  wire logic [7:0] o_buffer,
  input  wire logic [7:0] o_status,
  input  wire logic       o_port_irq,
  input  wire logic       o_scl,
  input  wire logic       o_sda,
  input  wire logic       o_scl_oe_n,
  input  wire logic       o_sda_oe_n
);
  import i2c_slave_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic slave_mode;
  assign slave_mode = o_control[3:0] inside {MODE_SLV7, MODE_SLV10, MODE_SLV7_SP, MODE_SLV10_SP};

  chk_off_quiet: assert property (!o_control[CTL_EN] |-> o_scl_oe_n && o_sda_oe_n)
    else $error("pins pulled while port disabled");
  chk_mode_gate: assert property (!slave_mode |-> o_scl_oe_n && o_sda_oe_n)
    else $error("pins pulled outside slave modes");
  chk_dir_gate: assert property (i_pin_dir != 2'b11 |-> o_scl_oe_n && o_sda_oe_n)
    else $error("pins pulled while direction bits not input");
  chk_open_drain: assert property (!o_scl && !o_sda)
    else $error("pin output level not low");
  chk_ovf_sticky: assert property (o_control[CTL_OV] && !i_ctl_wr |=> o_control[CTL_OV])
    else $error("overflow flag cleared without control write");
  chk_ovf_cause: assert property (!$past(i_ctl_wr) && $rose(o_control[CTL_OV])
                                  |-> $past(o_status[ST_BF]))
    else $error("overflow set while buffer was empty");
  chk_full_no_load: assert property (o_status[ST_BF] && !i_buf_wr |=> $stable(o_buffer))
    else $error("buffer overwritten while full");
  chk_ack_needs_full: assert property ($fell(o_sda_oe_n) |-> o_status[ST_BF])
    else $error("data line pulled with buffer empty");
  chk_clock_release: assert property (o_control[CTL_CKP] && $past(o_control[CTL_CKP]) &&
                                      !o_status[ST_UA] && !$past(o_status[ST_UA]) |-> o_scl_oe_n)
    else $error("clock held while release bit set");
  chk_flags_off: assert property (!o_control[CTL_EN] && !$past(o_control[CTL_EN])
                                  |-> o_status[ST_STOP:ST_START] == 2'b00)
    else $error("start or stop flag set while disabled");
  chk_irq_sticky: assert property (o_port_irq && !i_irq_clr |=> o_port_irq)
    else $error("interrupt flag dropped without clear");

  cover property ($rose(o_port_irq));
  cover property ($rose(o_control[CTL_OV]));
  cover property ($fell(o_scl_oe_n));
endmodule

bind i2c_slave_serial_port i2c_slave_serial_port_monitor u_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_ctl_wr(i_ctl_wr), .i_buf_wr(i_buf_wr),
  .i_irq_clr(i_irq_clr), .i_pin_dir(i_pin_dir), .o_control(o_control),
  .o_buffer(o_buffer), .o_status(o_status), .o_port_irq(o_port_irq), .o_scl(o_scl),
  .o_sda(o_sda), .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n)
);

//--- i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  // Wired bus levels
  input  wire logic i_scl_line,
  input  wire logic i_sda_line,
  // Pull-down requests
  output logic      o_scl_low,
  output logic      o_sda_low
);
  localparam int HALF_NS = 40;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // ----------------------------------------------------------------
  // Bus conditions and bytes
  // ----------------------------------------------------------------
  task automatic wait_scl();
    int n;
    n = 0;
    while (i_scl_line !== 1'b1 && n < 4000) begin
      #8;
      n++;
    end
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    #HALF_NS;
    o_scl_low = 1'b0;
    wait_scl();
    #HALF_NS;
    o_sda_low = 1'b1;
    #HALF_NS;
    o_scl_low = 1'b1;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    #HALF_NS;
    o_scl_low = 1'b0;
    wait_scl();
    #HALF_NS;
    o_sda_low = 1'b0;
    #HALF_NS;
  endtask
  // Last is the ninth bit sent; 1 releases the line
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
                      output logic ack);
    logic [8:0] word;
    word = {d, last};
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~word[i];
      #HALF_NS;
      o_scl_low = 1'b0;
      wait_scl();
      if (i > 0) r = {r[6:0], i_sda_line};
      else ack = ~i_sda_line;
      #HALF_NS;
      o_scl_low = 1'b1;
    end
    o_sda_low = 1'b0;
  endtask
endmodule

//--- i2c_slave_serial_port_bench.sv
`timescale 1ns/1ps
`define CMP(e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t expected %h got %h", $time, e, a); end end
module i2c_slave_serial_port_bench;
  import i2c_slave_pkg::*;
  localparam logic [4:0] CTL = 5'h10, BWR = 5'h08, BRD = 5'h04, AWR = 5'h02, ICL = 5'h01;
  localparam logic [3:0] MODES [5] = '{MODE_SLV7, MODE_SLV10, MODE_FWM, MODE_SLV7_SP,
                                       MODE_SLV10_SP};
  logic       i_clk, i_rst, i_ctl_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_irq_clr;
  logic [7:0] i_ctl_wdata, i_buf_wdata, i_addr_wdata, o_control, o_buffer, o_own_addr;
  logic [7:0] o_status, obs, e_v, r, d;
  logic [1:0] i_pin_dir;
  logic       o_port_irq, o_scl, o_sda, o_scl_oe_n, o_sda_oe_n, a;
  logic       scl_line, sda_line, m_scl_low, m_sda_low;
  logic [7:0] exp_q [$];
  int         n_errors = 0, total_checks = 0, cyc = 0, seed;
  event       obs_ev;

  // ----------------------------------------------------------------
  // Device, far-side master and pulled-up wires
  // ----------------------------------------------------------------
  i2c_slave_serial_port uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata),
    .o_control(o_control), .i_buf_wr(i_buf_wr), .i_buf_wdata(i_buf_wdata),
    .i_buf_rd(i_buf_rd), .o_buffer(o_buffer), .i_addr_wr(i_addr_wr),
    .i_addr_wdata(i_addr_wdata), .o_own_addr(o_own_addr), .o_status(o_status),
    .i_irq_clr(i_irq_clr), .o_port_irq(o_port_irq), .i_pin_dir(i_pin_dir),
    .i_scl(scl_line), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_line),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n)
  );
  i2c_master_model m (
    .i_scl_line(scl_line), .i_sda_line(sda_line), .o_scl_low(m_scl_low),
    .o_sda_low(m_sda_low)
  );
  assign scl_line = ~(m_scl_low | ~o_scl_oe_n);
  assign sda_line = ~(m_sda_low | ~o_sda_oe_n);

  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Notes, watcher and software access
  // ----------------------------------------------------------------
  always @(obs_ev) begin
    e_v = exp_q.pop_front();
    `CMP(e_v, obs)
  end
  task automatic check(input logic [7:0] e, input logic [7:0] act);
    exp_q.push_back(e);
    obs = act;
    ->obs_ev;
    #0;
  endtask
  task automatic sw(input logic [4:0] s, input logic [7:0] v);
    @(posedge i_clk);
    {i_ctl_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_irq_clr} <= s;
    i_ctl_wdata <= v;
    i_buf_wdata <= v;
    i_addr_wdata <= v;
    @(posedge i_clk);
    {i_ctl_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_irq_clr} <= 5'h00;
  endtask
  task automatic settle();
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hfd047cd9;
    i_rst = 1'b1;
    {i_ctl_wr, i_buf_wr, i_buf_rd, i_addr_wr, i_irq_clr} = 5'h00;
    {i_ctl_wdata, i_buf_wdata, i_addr_wdata} = 24'h00_0000;
    i_pin_dir = 2'b11;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    settle();
    check(CTL_RESET, o_control);
    check(STAT_RESET, o_status);
    check(BUF_RESET, o_buffer);
    check(ADDR_RESET, o_own_addr);
    done("reset");
    sw(AWR, 8'hA0);
    sw(CTL, {4'h0, MODE_SLV7});
    m.start();
    m.xfer(8'hA0, 1'b1, r, a);
    m.stop();
    settle();
    check(8'h00, 8'(a));
    check(8'h00, o_status);
    done("disabled");
    foreach (MODES[i]) begin
      sw(CTL, {4'h3, MODES[i]});
      sw(ICL, 8'h00);
      settle();
      check(8'h00, 8'(o_port_irq));
      m.start();
      settle();
      check(8'h08, o_status & 8'h18);
      m.stop();
      settle();
      check(8'h10, o_status & 8'h18);
      check(8'(MODES[i][3]), 8'(o_port_irq));
    end
    sw(CTL, 8'h06);
    settle();
    check(8'h00, o_status & 8'h18);
    done("modes");
    sw(CTL, 8'h36);
    m.start();
    m.xfer(8'hA0, 1'b1, r, a);
    settle();
    check(8'h01, 8'(a));
    check(8'hA0, o_buffer);
    check(8'h01, o_status & 8'h05);
    check(8'h01, 8'(o_port_irq));
    sw(ICL, 8'h00);
    d = 8'($random(seed));
    m.xfer(d, 1'b1, r, a);
    settle();
    check(8'h00, 8'(a));
    check(8'hA0, o_buffer);
    check(8'h40, o_control & 8'h40);
    check(8'h01, 8'(o_port_irq));
    sw(BRD, 8'h00);
    settle();
    check(8'h40, o_control & 8'h40);
    check(8'h00, o_status & 8'h01);
    sw(CTL, 8'h36);
    d = 8'($random(seed));
    m.xfer(d, 1'b1, r, a);
    settle();
    check(8'h01, 8'(a));
    check(d, o_buffer);
    m.stop();
    sw(BRD, 8'h00);
    sw(AWR, 8'h00);
    m.start();
    m.xfer(8'h00, 1'b1, r, a);
    settle();
    check(8'h00, 8'(a));
    sw(AWR, 8'hA0);
    m.start();
    m.xfer(8'hA2, 1'b1, r, a);
    m.stop();
    settle();
    check(8'h00, 8'(a));
    done("receive");
    m.start();
    m.xfer(8'hA1, 1'b1, r, a);
    settle();
    check(8'h01, 8'(a));
    check(8'h04, o_status & 8'h04);
    check(8'h00, 8'(o_scl_oe_n));
    d = 8'($random(seed));
    sw(BWR, d);
    sw(ICL, 8'h00);
    sw(CTL, 8'h36);
    m.xfer(8'hFF, 1'b0, r, a);
    settle();
    check(d, r);
    check(8'h20, o_status & 8'h21);
    d = 8'($random(seed));
    sw(BWR, d);
    sw(ICL, 8'h00);
    sw(CTL, 8'h36);
    m.xfer(8'hFF, 1'b1, r, a);
    settle();
    check(d, r);
    check(8'h00, o_status & 8'h27);
    check(8'h01, 8'(o_port_irq));
    m.stop();
    done("transmit");
    sw(CTL, 8'h37);
    sw(AWR, {HDR10, 2'b01, 1'b0});
    sw(BRD, 8'h00);
    m.start();
    m.xfer({HDR10, 2'b01, 1'b0}, 1'b1, r, a);
    settle();
    check(8'h01, 8'(a));
    check(8'h03, o_status & 8'h03);
    sw(AWR, 8'h5A);
    sw(BRD, 8'h00);
    m.xfer(8'h5A, 1'b1, r, a);
    settle();
    check(8'h01, 8'(a));
    check(8'h03, o_status & 8'h03);
    sw(AWR, {HDR10, 2'b01, 1'b0});
    sw(BRD, 8'h00);
    m.stop();
    done("ten_bit");
    end_of_test();
  end
endmodule
